// [bench/ddpwm_bridge.sv]
// Behavioural bridge driver that measures gate pulse widths
`timescale 1ns/1ns
module ddpwm_bridge
(
    input  wire logic clk_sys_i,
    input  wire logic gate_hi_i,
    input  wire logic gate_lo_i,
    output int        on_hi_o,
    output int        on_lo_o
);
    int run_hi = 0;
    int run_lo = 0;
    always @(posedge clk_sys_i)
    begin
        run_hi <= gate_hi_i ? run_hi + 1 : 0;
        run_lo <= gate_lo_i ? run_lo + 1 : 0;
        if (!gate_hi_i && run_hi != 0)
            on_hi_o <= run_hi;
        if (!gate_lo_i && run_lo != 0)
            on_lo_o <= run_lo;
    end
endmodule

// [bench/ddpwm_props.sv]
// Port checker of the dead-time waveform generator
`timescale 1ns/1ns
module ddpwm_props
#(parameter int DATA_W = 16)
(
    input wire logic              clk_sys_i,
    input wire logic              reset_n_i,
    input wire logic              reg_rd_i,
    input wire logic [DATA_W-1:0] reg_rdata_o,
    input wire logic              wave_out_a_o,
    input wire logic              wave_out_b_o,
    input wire logic              wave_out_extra0_o,
    input wire logic              chain_sync_out_o,
    input wire logic              chain_halt_out_o,
    input wire logic              converter_sync_pulse_o,
    input wire logic              generator_irq_o
);
    default clocking @(posedge clk_sys_i);
    endclocking
    default disable iff (!reset_n_i);
    // Generator held stopped for three clocks
    sequence s_stopped;
        chain_halt_out_o [*3];
    endsequence
    a_rdata_idle:
        assert property (!$past(reg_rd_i) |-> reg_rdata_o == '0) else $error("stray read data");
    a_reset_state:
        assert property (!$past(reset_n_i) |-> chain_halt_out_o && !generator_irq_o)
        else $error("bad state after reset");
    a_halt_quiet:
        assert property (s_stopped |-> !chain_sync_out_o && !converter_sync_pulse_o)
        else $error("pulse while stopped");
    a_outputs_idle:
        assert property (s_stopped |-> wave_out_a_o == wave_out_b_o) else $error("outputs active");
    a_out_stable:
        assert property (s_stopped |-> $stable(wave_out_a_o)) else $error("output moves");
    a_extra_copy:
        assert property (s_stopped |-> wave_out_extra0_o == wave_out_a_o) else $error("extra differs");
    a_sync_single:
        assert property (chain_sync_out_o |=> !chain_sync_out_o) else $error("long sync pulse");
    a_adc_single:
        assert property (converter_sync_pulse_o |=> !converter_sync_pulse_o)
        else $error("long converter pulse");
endmodule
bind ddpwm_core ddpwm_props #(.DATA_W(DATA_W)) u_props (.*);

// [bench/tb_top.sv]
// Self-checking bench of the dead-time waveform generator
`timescale 1ns/1ns
module tb_top
    import ddpwm_pkg::*;
;
    logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
    logic        retrigger_i = 1'b0, fault_i = 1'b0;
    logic [3:0]  reg_addr_i = 4'h0;
    logic [15:0] reg_wdata_i = 16'h0000, reg_rdata_o;
    logic        wave_out_a_o, wave_out_b_o, chain_sync_out_o, generator_irq_o;
    logic        wave_out_extra0_o, wave_out_extra1_o, chain_halt_out_o, converter_sync_pulse_o;
    int          n_fail = 0, cmp_count = 0, seed = 90371, on_a, on_b, v[4], n_adc = 0;
    ddpwm_core dut (.clk_sys_i, .reset_n_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
        .reg_rdata_o, .retrigger_i, .fault_i, .wave_out_a_o, .wave_out_b_o,
        .wave_out_extra0_o, .wave_out_extra1_o, .chain_sync_out_o,
        .chain_halt_out_o, .converter_sync_pulse_o, .generator_irq_o);
    ddpwm_bridge u_br (.clk_sys_i, .gate_hi_i(wave_out_a_o), .gate_lo_i(wave_out_b_o),
        .on_hi_o(on_a), .on_lo_o(on_b));
    initial
        forever #2 clk_sys_i = ~clk_sys_i;
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("MISMATCH %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] e, input logic [15:0] m);
        @(posedge clk_sys_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clk_sys_i);
        reg_rd_i <= 1'b0;
        @(negedge clk_sys_i);
        chk(reg_rdata_o & m, e);
    endtask
    // Counts cycle ends, bounded
    task automatic syncs(input int n);
        for (int t = 0; n > 0; t++)
        begin
            @(posedge clk_sys_i);
            n -= int'(chain_sync_out_o === 1'b1);
            n_adc += int'(converter_sync_pulse_o === 1'b1);
            if (t > 4000)
            begin
                chk(16'h0000, 16'h0001);
                complete_run();
            end
        end
    endtask
    function automatic int expv(input int m, input bit b);
        case (m)
            0: return b ? v[3] : v[1];
            3: return b ? 2 * (v[3] - v[2] + 1) : 2 * v[0];
            default: return b ? v[3] - v[2] : v[1] - v[0];
        endcase
    endfunction
    task automatic complete_run();
        $display("compares %0d fails %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge clk_sys_i);
        reset_n_i <= 1'b1;
        rdc(DDPWM_REG_OUT_CFG, 16'h0004, 16'hFFFF);
        chk({15'h0000, chain_halt_out_o}, 16'h0001);
        rdc(DDPWM_REG_GEN_CFG, 16'h0000, 16'hFFFF);
        rdc(4'h9, 16'h0000, 16'hFFFF);
        for (int i = 0; i < 4; i++)
        begin
            v[i] = $random(seed);
            rdc(4'(i), 16'h0000, 16'hFFFF);
            wr(4'(i), 16'(v[i]));
            rdc(4'(i), 16'(v[i]) & 16'h0FFF, 16'hFFFF);
        end
        // Extra output 0 follows b, extra output 1 follows a
        wr(DDPWM_REG_OUT_CFG, 16'h000F);
        for (int m = 0; m < 4; m++)
        begin
            wr(DDPWM_REG_GEN_CFG, 16'h0000);
            v[0] = 1 + {$random(seed)} % 4;
            for (int i = 1; i < 4; i++)
                v[i] = v[i-1] + 1 + {$random(seed)} % 4;
            for (int i = 0; i < 4; i++)
                wr(4'(i), 16'(v[i]));
            wr(DDPWM_REG_GEN_CFG, 16'(2 * m + 1));
            syncs(1);
            n_adc = 0;
            syncs(2);
            chk(16'(n_adc), 16'h0002);
            chk(16'(on_a), 16'(expv(m, 1'b0)));
            chk(16'(on_b), 16'(expv(m, 1'b1)));
            repeat (8)
            begin
                @(negedge clk_sys_i);
                chk(16'(wave_out_extra0_o ^ wave_out_b_o), 16'h0000);
                chk(16'(wave_out_extra1_o ^ wave_out_a_o), 16'h0000);
            end
            chk({15'h0000, chain_halt_out_o}, 16'h0000);
        end
        wr(DDPWM_REG_GEN_CFG, 16'h0013);
        syncs(2);
        wr(DDPWM_REG_RESET_A, 16'(v[1] + 3));
        syncs(3);
        chk(16'(on_a), 16'(v[1] - v[0]));
        wr(DDPWM_REG_GEN_CFG, 16'h0003);
        syncs(3);
        chk(16'(on_a), 16'(v[1] + 3 - v[0]));
        wr(DDPWM_REG_GEN_CFG, 16'h0033);
        syncs(3);
        wr(DDPWM_REG_RESET_A, 16'(v[1]));
        syncs(3);
        chk(16'(on_a), 16'(v[1] + 3 - v[0]));
        wr(DDPWM_REG_RESET_B, 16'(v[3]));
        syncs(3);
        chk(16'(on_a), 16'(v[1] - v[0]));
        wr(DDPWM_REG_GEN_CFG, 16'h0000);
        wr(DDPWM_REG_GEN_CFG, 16'h000B);
        wr(DDPWM_REG_RESET_B, 16'(v[3]));
        syncs(3);
        chk(16'(on_a), 16'(v[3] - v[2]));
        wr(DDPWM_REG_GEN_CFG, 16'h0100);
        wr(DDPWM_REG_FLAGS, 16'h0007);
        rdc(DDPWM_REG_FLAGS, 16'h0000, 16'h0007);
        chk({15'h0000, generator_irq_o}, 16'h0000);
        // One ramp, slowest tick: counter sits at 1 from clock 64 to 127 after start
        wr(DDPWM_REG_GEN_CFG, 16'h01C5);
        repeat (100) @(posedge clk_sys_i);
        fault_i <= 1'b1;
        retrigger_i <= 1'b1;
        repeat (6) @(negedge clk_sys_i);
        chk({15'h0000, generator_irq_o}, 16'h0001);
        rdc(DDPWM_REG_FLAGS, 16'h0006, 16'h0007);
        rdc(DDPWM_REG_CAPTURE, 16'h0001, 16'h0FFF);
        complete_run();
    end
endmodule

// [hdl/ddpwm_core.sv]
// Dead-time waveform generator with buffered compare values and lock control
`timescale 1ns/1ns

module ddpwm_core
    import ddpwm_pkg::*;
#(
    parameter int          CMP_W         = 12,
    parameter int          DATA_W        = 16,
    parameter bit          EXTRA_OUTPUTS = 1'b1
)
(
    input  wire logic              clk_sys_i,
    input  wire logic              reset_n_i,
    input  wire logic [3:0]        reg_addr_i,
    input  wire logic [DATA_W-1:0] reg_wdata_i,
    input  wire logic              reg_wr_i,
    input  wire logic              reg_rd_i,
    output logic      [DATA_W-1:0] reg_rdata_o,
    input  wire logic              retrigger_i,
    input  wire logic              fault_i,
    output logic                   wave_out_a_o,
    output logic                   wave_out_b_o,
    output logic                   wave_out_extra0_o,
    output logic                   wave_out_extra1_o,
    output logic                   chain_sync_out_o,
    output logic                   chain_halt_out_o,
    output logic                   converter_sync_pulse_o,
    output logic                   generator_irq_o
);

    // ==========================================================
    // Elaboration checks
    // ==========================================================
    if (CMP_W != 12) begin : g_bad_cmp
        $error("Compare width must be 12");
    end
    if (DATA_W < 16) begin : g_bad_data
        $error("Register data width must be at least 16");
    end

    // ==========================================================
    // State
    // ==========================================================
    typedef struct packed {
        logic [CMP_W-1:0]          set_a;
        logic [CMP_W-1:0]          reset_a;
        logic [CMP_W-1:0]          set_b;
        logic [CMP_W-1:0]          reset_b;
        logic [DDPWM_OC_W-1:0]     out_cfg;
        logic [DDPWM_MATRIX_W-1:0] matrix;
        logic [DDPWM_GC_W-1:0]     gen_cfg;
        logic [CMP_W-1:0]          act_sa;
        logic [CMP_W-1:0]          act_ra;
        logic [CMP_W-1:0]          act_sb;
        logic [CMP_W-1:0]          act_rb;
        logic [DDPWM_OC_W-1:0]     act_cfg;
        logic [DDPWM_MATRIX_W-1:0] act_matrix;
        logic                      auto_eff;
        logic                      pending;
        logic                      last_rb;
        logic [5:0]                presc;
        logic [CMP_W:0]            cnt;
        logic                      phase_b;
        logic                      down;
        logic [CMP_W-1:0]          capture;
        logic [DDPWM_FL_W-1:0]     flags;
        logic [DATA_W-1:0]         rdata;
        logic                      out_a;
        logic                      out_b;
        logic                      out_x0;
        logic                      out_x1;
        logic                      sync;
        logic                      halt;
        logic                      adc_sync;
        logic                      irq;
        logic                      ret_s1;
        logic                      ret_s2;
        logic                      ret_s3;
        logic                      flt_s1;
        logic                      flt_s2;
        logic                      flt_s3;
    } ddpwm_state_s;

    ddpwm_state_s st_q;
    ddpwm_state_s st_d;

    // ==========================================================
    // Combinational helpers
    // ==========================================================
    ddpwm_mode_e      mode;
    logic             run;
    logic [5:0]       tick_mask;
    logic             tick;
    logic [CMP_W:0]   sa_w;
    logic [CMP_W:0]   ra_w;
    logic [CMP_W:0]   sb_w;
    logic [CMP_W:0]   rb_w;
    logic [CMP_W:0]   ramp_end;
    logic             raw_a;
    logic             raw_b;
    logic             cycle_end;
    logic             peak;
    logic             upd_ok;
    logic             do_load;
    logic             wr_cmp;
    logic             pol;
    logic             drv_a;
    logic             drv_b;
    logic [DDPWM_FL_W-1:0] flag_set;
    logic [DDPWM_FL_W-1:0] flag_clr;
    logic [DATA_W-1:0]     rd_mux;

    assign mode = ddpwm_mode_e'(st_q.gen_cfg[DDPWM_GC_MODE_LO +: 2]);
    assign run  = st_q.gen_cfg[DDPWM_GC_RUN];
    assign sa_w = {1'b0, st_q.act_sa};
    assign ra_w = {1'b0, st_q.act_ra};
    assign sb_w = {1'b0, st_q.act_sb};
    assign rb_w = {1'b0, st_q.act_rb};
    assign pol  = st_q.act_cfg[DDPWM_OC_POL];

    // Generator clock is a divided enable of the system clock
    // single clock domain
    always_comb
    begin
        case (st_q.gen_cfg[DDPWM_GC_CLKSEL +: 2])
            2'b00:   tick_mask = 6'h00;
            2'b01:   tick_mask = 6'h03;
            2'b10:   tick_mask = 6'h0F;
            default: tick_mask = 6'h3F;
        endcase
    end
    assign tick = (st_q.presc & tick_mask) == tick_mask;

    // Ramp length and output levels per mode
    // mode selects waveform
    always_comb
    begin
        ramp_end = rb_w;
        raw_a    = 1'b0;
        raw_b    = 1'b0;
        case (mode)
            DDPWM_MODE_FOUR:
            begin
                ramp_end = st_q.phase_b ? (sb_w + rb_w + 13'h0001)
                                        : (sa_w + ra_w + 13'h0001);
                raw_a    = !st_q.phase_b && (st_q.cnt > (sa_w + 13'h0001));
                raw_b    = st_q.phase_b && (st_q.cnt > (sb_w + 13'h0001));
            end
            DDPWM_MODE_TWO:
            begin
                ramp_end = st_q.phase_b ? rb_w : ra_w;
                raw_a    = !st_q.phase_b && (st_q.cnt > sa_w);
                raw_b    = st_q.phase_b && (st_q.cnt > sb_w);
            end
            DDPWM_MODE_ONE:
            begin
                ramp_end = rb_w;
                raw_a    = (st_q.cnt > sa_w) && (st_q.cnt <= ra_w);
                raw_b    = (st_q.cnt > sb_w) && (st_q.cnt <= rb_w);
            end
            DDPWM_MODE_CENTER:
            begin
                ramp_end = rb_w;
                raw_a    = st_q.cnt < sa_w;
                raw_b    = st_q.cnt >= sb_w;
            end
            default:
            begin
                ramp_end = rb_w;
            end
        endcase
    end

    always_comb
    begin
        cycle_end = 1'b0;
        peak      = 1'b0;
        if (run && tick)
        begin
            case (mode)
                DDPWM_MODE_FOUR, DDPWM_MODE_TWO:
                    cycle_end = st_q.phase_b && (st_q.cnt >= ramp_end);
                DDPWM_MODE_ONE:
                    cycle_end = st_q.cnt >= ramp_end;
                DDPWM_MODE_CENTER:
                begin
                    cycle_end = st_q.down && (st_q.cnt == 13'h0000);
                    peak      = !st_q.down && (st_q.cnt >= ramp_end);
                end
                default:
                    cycle_end = 1'b0;
            endcase
        end
    end

    // auto-lock waits for RB written last
    assign upd_ok = st_q.pending &&
                    (st_q.auto_eff ? st_q.last_rb : !st_q.gen_cfg[DDPWM_GC_LOCK]);

    // load at top of last ramp
    assign do_load = (!run && st_q.pending) ||
                     (upd_ok && ((mode == DDPWM_MODE_CENTER) ? peak : cycle_end));

    assign wr_cmp = reg_wr_i && (reg_addr_i <= DDPWM_REG_OUT_MATRIX);

    // Output drive with matrix option and polarity
    // part A to a, part B to b
    always_comb
    begin
        drv_a = raw_a;
        drv_b = raw_b;
        if (st_q.act_cfg[DDPWM_OC_MATRIX_EN])
        begin
            drv_a = st_q.phase_b ? st_q.act_matrix[2] : st_q.act_matrix[0];
            drv_b = st_q.phase_b ? st_q.act_matrix[3] : st_q.act_matrix[1];
        end
        drv_a = (run && st_q.act_cfg[DDPWM_OC_EN_A]) ? drv_a : 1'b0;
        drv_b = (run && st_q.act_cfg[DDPWM_OC_EN_B]) ? drv_b : 1'b0;
    end

    // Flag events and write-one clears
    assign flag_set = {st_q.ret_s2 && !st_q.ret_s3,
                       st_q.flt_s2 && !st_q.flt_s3,
                       cycle_end};
    assign flag_clr = (reg_wr_i && (reg_addr_i == DDPWM_REG_FLAGS))
                      ? reg_wdata_i[DDPWM_FL_W-1:0] : '0;

    // Register read mux
    always_comb
    begin
        rd_mux = '0;
        case (reg_addr_i)
            DDPWM_REG_SET_A:      rd_mux[CMP_W-1:0] = st_q.set_a;
            DDPWM_REG_RESET_A:    rd_mux[CMP_W-1:0] = st_q.reset_a;
            DDPWM_REG_SET_B:      rd_mux[CMP_W-1:0] = st_q.set_b;
            DDPWM_REG_RESET_B:    rd_mux[CMP_W-1:0] = st_q.reset_b;
            DDPWM_REG_OUT_CFG:    rd_mux[DDPWM_OC_W-1:0] = st_q.out_cfg;
            DDPWM_REG_OUT_MATRIX: rd_mux[DDPWM_MATRIX_W-1:0] = st_q.matrix;
            DDPWM_REG_GEN_CFG:    rd_mux[DDPWM_GC_W-1:0] = st_q.gen_cfg;
            DDPWM_REG_CAPTURE:    rd_mux[CMP_W-1:0] = st_q.capture;
            DDPWM_REG_FLAGS:
            begin
                rd_mux[DDPWM_FL_W-1:0]   = st_q.flags;
                rd_mux[DDPWM_ST_RUNNING] = run;
                rd_mux[DDPWM_ST_PHASE_B] = st_q.phase_b;
                rd_mux[DDPWM_ST_PENDING] = st_q.pending;
            end
            default:              rd_mux = '0;
        endcase
    end

    // ==========================================================
    // Next state
    // ==========================================================
    always_comb
    begin
        st_d = st_q;

        st_d.ret_s1 = retrigger_i;
        st_d.ret_s2 = st_q.ret_s1;
        st_d.ret_s3 = st_q.ret_s2;
        st_d.flt_s1 = fault_i;
        st_d.flt_s2 = st_q.flt_s1;
        st_d.flt_s3 = st_q.flt_s2;
        st_d.presc  = st_q.presc + 6'h01;

        if (!run)
        begin
            st_d.cnt     = '0;
            st_d.phase_b = 1'b0;
            st_d.down    = 1'b0;
            st_d.presc   = 6'h00;
        end
        else if (tick)
        begin
            case (mode)
                DDPWM_MODE_FOUR, DDPWM_MODE_TWO:
                begin
                    if (st_q.cnt >= ramp_end)
                    begin
                        st_d.cnt     = '0;
                        st_d.phase_b = !st_q.phase_b;
                    end
                    else
                    begin
                        st_d.cnt = st_q.cnt + 13'h0001;
                    end
                end
                DDPWM_MODE_ONE:
                begin
                    st_d.phase_b = 1'b0;
                    st_d.cnt = (st_q.cnt >= ramp_end) ? 13'h0000 : st_q.cnt + 13'h0001;
                end
                DDPWM_MODE_CENTER:
                begin
                    st_d.phase_b = 1'b0;
                    if (!st_q.down)
                    begin
                        if (st_q.cnt >= ramp_end)
                            st_d.down = 1'b1;
                        else
                            st_d.cnt = st_q.cnt + 13'h0001;
                    end
                    else if (st_q.cnt == 13'h0000)
                        st_d.down = 1'b0;
                    else
                        st_d.cnt = st_q.cnt - 13'h0001;
                end
                default:
                    st_d.cnt = '0;
            endcase
        end

        if (cycle_end || !run)
            st_d.auto_eff = st_q.gen_cfg[DDPWM_GC_AUTO_LATCH_ON_LAST_WRITE];

        if (do_load)
        begin
            st_d.act_sb     = st_q.set_b;
            st_d.act_rb     = st_q.reset_b;
            st_d.act_sa     = st_q.gen_cfg[DDPWM_GC_FIFTY] ? st_q.set_b : st_q.set_a;
            st_d.act_ra     = st_q.gen_cfg[DDPWM_GC_FIFTY] ? st_q.reset_b : st_q.reset_a;
            st_d.act_cfg    = st_q.out_cfg;
            st_d.act_matrix = st_q.matrix;
            st_d.pending    = 1'b0;
            st_d.last_rb    = 1'b0;
        end

        // Register writes; a write to registers 0 to 5 in a load cycle keeps pending set
        // 12-bit compares
        if (reg_wr_i)
        begin
            case (reg_addr_i)
                DDPWM_REG_SET_A:      st_d.set_a   = reg_wdata_i[CMP_W-1:0];
                DDPWM_REG_RESET_A:    st_d.reset_a = reg_wdata_i[CMP_W-1:0];
                DDPWM_REG_SET_B:      st_d.set_b   = reg_wdata_i[CMP_W-1:0];
                DDPWM_REG_RESET_B:    st_d.reset_b = reg_wdata_i[CMP_W-1:0];
                DDPWM_REG_OUT_CFG:    st_d.out_cfg = reg_wdata_i[DDPWM_OC_W-1:0];
                DDPWM_REG_OUT_MATRIX: st_d.matrix  = reg_wdata_i[DDPWM_MATRIX_W-1:0];
                DDPWM_REG_GEN_CFG:    st_d.gen_cfg = reg_wdata_i[DDPWM_GC_W-1:0];
                default:              st_d.gen_cfg = st_q.gen_cfg;
            endcase
        end
        if (wr_cmp)
        begin
            st_d.pending = 1'b1;
            st_d.last_rb = reg_addr_i == DDPWM_REG_RESET_B;
        end

        if (flag_set[DDPWM_FL_CAPTURE])
            st_d.capture = st_q.cnt[CMP_W-1:0];

        // Set wins over clear
        st_d.flags = (st_q.flags & ~flag_clr) | flag_set;

        st_d.irq = st_q.gen_cfg[DDPWM_GC_IRQ_EN] && (|st_d.flags);

        st_d.rdata = reg_rd_i ? rd_mux : '0;

        st_d.out_a = drv_a ? pol : !pol;
        st_d.out_b = drv_b ? pol : !pol;
        if (EXTRA_OUTPUTS)
        begin
            st_d.out_x0 = st_q.act_cfg[DDPWM_OC_X0_SEL] ? st_d.out_b : st_d.out_a;
            st_d.out_x1 = st_q.act_cfg[DDPWM_OC_X1_SEL] ? st_d.out_b : st_d.out_a;
        end
        else
        begin
            st_d.out_x0 = 1'b0;
            st_d.out_x1 = 1'b0;
        end

        st_d.sync = cycle_end;
        st_d.halt = !run;
        // RA places converter sync in center mode
        if (mode == DDPWM_MODE_CENTER)
            st_d.adc_sync = run && tick && !st_q.down && (st_q.cnt == ra_w);
        else
            st_d.adc_sync = run && tick && (st_q.cnt == 13'h0000) && !st_q.phase_b;
    end

    // ==========================================================
    // Registers
    // ==========================================================
    // reset to stopped, inactive
    always_ff @(posedge clk_sys_i)
    begin
        if (!reset_n_i)
        begin
            st_q         <= '0;
            st_q.set_a   <= DDPWM_CMP_RST;
            st_q.reset_a <= DDPWM_CMP_RST;
            st_q.set_b   <= DDPWM_CMP_RST;
            st_q.reset_b <= DDPWM_CMP_RST;
            st_q.out_cfg <= DDPWM_OUT_CFG_RST;
            st_q.act_cfg <= DDPWM_OUT_CFG_RST;
            st_q.matrix  <= DDPWM_MATRIX_RST;
            st_q.gen_cfg <= DDPWM_GEN_CFG_RST;
            st_q.halt    <= 1'b1;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    assign reg_rdata_o            = st_q.rdata;
    assign wave_out_a_o           = st_q.out_a;
    assign wave_out_b_o           = st_q.out_b;
    assign wave_out_extra0_o      = st_q.out_x0;
    assign wave_out_extra1_o      = st_q.out_x1;
    assign chain_sync_out_o       = st_q.sync;
    assign chain_halt_out_o       = st_q.halt;
    assign converter_sync_pulse_o = st_q.adc_sync;
    assign generator_irq_o        = st_q.irq;

endmodule

// [shared/ddpwm_pkg.sv]
// Register map, field positions, reset values and modes of the dead-time waveform generator
package ddpwm_pkg;

    // ==========================================================
    // Register indices on the plain register port
    // ==========================================================
    localparam logic [3:0] DDPWM_REG_SET_A      = 4'h0;
    localparam logic [3:0] DDPWM_REG_RESET_A    = 4'h1;
    localparam logic [3:0] DDPWM_REG_SET_B      = 4'h2;
    localparam logic [3:0] DDPWM_REG_RESET_B    = 4'h3;
    localparam logic [3:0] DDPWM_REG_OUT_CFG    = 4'h4;
    localparam logic [3:0] DDPWM_REG_OUT_MATRIX = 4'h5;
    localparam logic [3:0] DDPWM_REG_GEN_CFG    = 4'h6;
    localparam logic [3:0] DDPWM_REG_CAPTURE    = 4'h7;
    localparam logic [3:0] DDPWM_REG_FLAGS      = 4'h8;

    // ==========================================================
    // Generator configuration fields
    // ==========================================================
    localparam int DDPWM_GC_RUN      = 0;
    localparam int DDPWM_GC_MODE_LO  = 1;
    localparam int DDPWM_GC_FIFTY    = 3;
    localparam int DDPWM_GC_LOCK     = 4;
    localparam int DDPWM_GC_AUTO_LATCH_ON_LAST_WRITE = 5;
    localparam int DDPWM_GC_CLKSEL   = 6;
    localparam int DDPWM_GC_IRQ_EN   = 8;
    localparam int DDPWM_GC_W        = 9;

    // ==========================================================
    // Output configuration fields
    // ==========================================================
    localparam int DDPWM_OC_EN_A      = 0;
    localparam int DDPWM_OC_EN_B      = 1;
    localparam int DDPWM_OC_POL       = 2;
    localparam int DDPWM_OC_X0_SEL    = 3;
    localparam int DDPWM_OC_X1_SEL    = 4;
    localparam int DDPWM_OC_MATRIX_EN = 5;
    localparam int DDPWM_OC_W         = 6;
    localparam int DDPWM_MATRIX_W     = 4;

    // ==========================================================
    // Flag and status fields
    // ==========================================================
    localparam int DDPWM_FL_OVF     = 0;
    localparam int DDPWM_FL_FAULT   = 1;
    localparam int DDPWM_FL_CAPTURE = 2;
    localparam int DDPWM_FL_W       = 3;
    localparam int DDPWM_ST_RUNNING = 3;
    localparam int DDPWM_ST_PHASE_B = 4;
    localparam int DDPWM_ST_PENDING = 5;

    // ==========================================================
    // Reset values
    // ==========================================================
    localparam logic [DDPWM_OC_W-1:0]     DDPWM_OUT_CFG_RST = 6'h04;
    localparam logic [DDPWM_GC_W-1:0]     DDPWM_GEN_CFG_RST = 9'h000;
    localparam logic [DDPWM_MATRIX_W-1:0] DDPWM_MATRIX_RST  = 4'h0;
    localparam logic [11:0]               DDPWM_CMP_RST     = 12'h000;

    // ==========================================================
    // Running modes
    // ==========================================================
    typedef enum logic [1:0] {
        DDPWM_MODE_FOUR   = 2'b00,
        DDPWM_MODE_TWO    = 2'b01,
        DDPWM_MODE_ONE    = 2'b10,
        DDPWM_MODE_CENTER = 2'b11
    } ddpwm_mode_e;

endpackage
